//--- espp_device.sv
// Encoder end: programming entry, erase, word writes and one-shot verify
`timescale 1ns/100ps
module espp_device #(
	parameter int SETUP_MIN   = espp_pkg::SETUP_MIN_CYC,
	// Internal op times follow the scale of the setup window
	parameter int ERASE_OP    = espp_pkg::ERASE_OP_US * SETUP_MIN / espp_pkg::SETUP_MIN_US,
	parameter int WRITE_OP    = espp_pkg::WRITE_OP_US * SETUP_MIN / espp_pkg::SETUP_MIN_US
) (
	input  wire logic                            clock,
	input  wire logic                            nrst,
	espp_if.device                               link,
	output logic                                 prog_active,
	output logic                                 sync_mode,
	output logic                                 write_busy,
	output logic                                 verify_done,
	output logic [espp_pkg::IMAGE_BITS-1:0]      image
);

	localparam int IB = espp_pkg::IMAGE_BITS;
	localparam int WB = espp_pkg::WORD_BITS;
	localparam int NW = espp_pkg::IMAGE_WORDS;

	initial
	begin
		if (SETUP_MIN < 2 || ERASE_OP < 1 || WRITE_OP < 1)
			$error("espp_device: bad timing parameters");
	end

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_ERASE  = 3'b011,
		ST_LOAD   = 3'b010,
		ST_WRITE  = 3'b110,
		ST_VERIFY = 3'b111,
		ST_SYNC   = 3'b101,
		ST_DONE   = 3'b100
	} espp_state_e;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sclk_s_r, d_s_r, b1_s_r, b0_s_r;
	logic       sclk_prev_r;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sclk_s_r    <= 2'h0;
			d_s_r       <= 2'h0;
			b1_s_r      <= 2'h0;
			b0_s_r      <= 2'h0;
			sclk_prev_r <= 1'b0;
		end
		else
		begin
			sclk_s_r    <= {sclk_s_r[0], link.serial_clock_button_input};
			d_s_r       <= {d_s_r[0], link.data_line};
			b1_s_r      <= {b1_s_r[0], link.button_input_one};
			b0_s_r      <= {b0_s_r[0], link.button_input_zero};
			sclk_prev_r <= sclk_s_r[1];
		end
	end

	logic sclk, din, sclk_rise, sclk_fall;
	assign sclk      = sclk_s_r[1];
	assign din       = d_s_r[1];
	assign sclk_rise = sclk & ~sclk_prev_r;
	assign sclk_fall = ~sclk & sclk_prev_r;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	espp_state_e        state_r;
	logic [31:0]        cnt_r;
	logic [$clog2(IB+1)-1:0] bit_r;
	logic [WB-1:0]      word_r;
	logic [IB-1:0]      array_r;
	logic               programmed_r;
	logic               verify_used_r;
	logic               dout_r;
	logic               dout_oe_r;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r       <= ST_IDLE;
			cnt_r         <= 32'h0;
			bit_r         <= '0;
			word_r        <= '0;
			array_r       <= espp_pkg::IMAGE_RESET;
			programmed_r  <= 1'b0;
			verify_used_r <= 1'b0;
			dout_r        <= 1'b0;
			dout_oe_r     <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					cnt_r <= sclk ? cnt_r + 32'h1 : 32'h0;
					// Entry needs clock button held long enough before data rises
					if (sclk && din && cnt_r >= 32'(SETUP_MIN))
					begin
						state_r <= ST_SETUP;
						cnt_r   <= 32'h0;
					end
					// Data rising before the setup time is reached restarts the count
					if (sclk && din && cnt_r < 32'(SETUP_MIN))
						cnt_r <= 32'h0;
				end
				ST_SETUP:
				begin
					if (sclk_fall)
					begin
						if (b1_s_r[1] || b0_s_r[1])
							state_r <= ST_SYNC;
						else
						begin
							state_r       <= ST_ERASE;
							array_r       <= '0;
							programmed_r  <= 1'b0;
							verify_used_r <= 1'b0;
							cnt_r         <= 32'h0;
						end
					end
				end
				ST_SYNC:
				begin
					if (!sclk && !din)
						state_r <= ST_IDLE;
				end
				ST_ERASE:
				begin
					cnt_r <= cnt_r + 32'h1;
					if (cnt_r >= 32'(ERASE_OP - 1))
					begin
						state_r <= ST_LOAD;
						bit_r   <= '0;
					end
				end
				ST_LOAD:
				begin
					if (sclk_fall)
					begin
						word_r <= {din, word_r[WB-1:1]};
						if (bit_r[$clog2(WB)-1:0] == ($clog2(WB))'(WB - 1))
						begin
							state_r <= ST_WRITE;
							cnt_r   <= 32'h0;
						end
						bit_r <= bit_r + 1'b1;
					end
				end
				ST_WRITE:
				begin
					cnt_r <= cnt_r + 32'h1;
					if (cnt_r == 32'h0)
						array_r[(32'(bit_r) - 32'(WB)) +: WB] <= word_r;
					if (cnt_r >= 32'(WRITE_OP - 1))
					begin
						if (32'(bit_r) >= 32'(IB))
						begin
							programmed_r <= 1'b1;
							state_r      <= ST_VERIFY;
							bit_r        <= '0;
						end
						else
							state_r <= ST_LOAD;
					end
				end
				ST_VERIFY:
				begin
					if (!programmed_r)
						state_r <= ST_DONE;
					else if (sclk_rise && !verify_used_r)
					begin
						dout_oe_r <= 1'b1;
						dout_r    <= array_r[bit_r[$clog2(IB)-1:0]];
						if (32'(bit_r) == 32'(IB - 1))
							verify_used_r <= 1'b1;
						bit_r <= bit_r + 1'b1;
					end
					// Last bit stays driven until the reader's falling edge
					else if (sclk_fall && verify_used_r)
						state_r <= ST_DONE;
				end
				ST_DONE:
				begin
					dout_oe_r     <= 1'b0;
					verify_used_r <= 1'b1;
					if (!sclk)
						state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	assign link.data_dev_o  = dout_r;
	assign link.data_dev_oe = dout_oe_r & (state_r == ST_VERIFY);
	assign prog_active      = (state_r != ST_IDLE) && (state_r != ST_SYNC) && (state_r != ST_DONE);
	assign sync_mode        = (state_r == ST_SYNC);
	assign write_busy       = (state_r == ST_ERASE) || (state_r == ST_WRITE);
	assign verify_done      = verify_used_r;
	assign image            = array_r;

endmodule

//--- espp_if.sv
// Pin-level link between programmer and encoder
`timescale 1ns/100ps
interface espp_if;
	logic sclk_o;
	logic sclk_oe;
	logic b1_o;
	logic b0_o;
	logic data_prog_o;
	logic data_prog_oe;
	logic data_dev_o;
	logic data_dev_oe;
	logic serial_clock_button_input;
	logic button_input_one;
	logic button_input_zero;
	logic data_line;

	// Clock button input has a pull-down; data line has a pull-down
	assign serial_clock_button_input = sclk_oe ? sclk_o : 1'b0;
	assign button_input_one          = b1_o;
	assign button_input_zero         = b0_o;
	assign data_line = data_prog_oe ? data_prog_o : (data_dev_oe ? data_dev_o : 1'b0);

	modport programmer (
		output sclk_o, sclk_oe, b1_o, b0_o, data_prog_o, data_prog_oe,
		input  data_line
	);
	modport device (
		input  serial_clock_button_input, button_input_one, button_input_zero, data_line,
		output data_dev_o, data_dev_oe
	);
endinterface

//--- espp_monitor.sv
// Link protocol checker for the programming port
`timescale 1ns/100ps
module espp_monitor #(
	parameter int PHASE      = 8,
	parameter int SETUP_MIN  = 20,
	parameter int SETUP_TGT  = 40,
	parameter int ERASE_WAIT = 40,
	parameter int WORD_WAIT  = 80
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic serial_clock_button_input,
	input wire logic button_input_one,
	input wire logic button_input_zero,
	input wire logic data_line,
	input wire logic data_prog_oe,
	input wire logic data_dev_oe,
	input wire logic data_dev_o
);
	logic        sclk;
	logic        entry;
	logic        sclk_r;
	logic        data_r;
	logic        entered_r;
	logic        erase_pend_r;
	logic [31:0] lo_cnt_r;
	logic [31:0] hi_cnt_r;
	logic [31:0] rise_cnt_r;

	assign sclk  = serial_clock_button_input;
	assign entry = sclk_r && !sclk && data_r && !data_line;

	// ----------------------------------------
	// Phase lengths and session tracking
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sclk_r   <= 1'b0;
			data_r   <= 1'b0;
			lo_cnt_r <= '0;
			hi_cnt_r <= '0;
		end
		else
		begin
			sclk_r   <= sclk;
			data_r   <= data_line;
			lo_cnt_r <= sclk ? '0 : lo_cnt_r + 32'h1;
			hi_cnt_r <= sclk ? hi_cnt_r + 32'h1 : '0;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			entered_r    <= 1'b0;
			erase_pend_r <= 1'b0;
			rise_cnt_r   <= '0;
		end
		else if (entry)
		begin
			entered_r    <= !button_input_one && !button_input_zero;
			erase_pend_r <= !button_input_one && !button_input_zero;
			rise_cnt_r   <= '0;
		end
		else if (sclk && !sclk_r)
		begin
			erase_pend_r <= 1'b0;
			rise_cnt_r   <= rise_cnt_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	chk_no_contention: assert property (!(data_prog_oe && data_dev_oe))
		else $error("Both ends drive the data line");
	chk_setup_hold: assert property ($rose(data_line) && data_prog_oe && sclk
		&& (!entered_r || rise_cnt_r >= 32'h180) |-> hi_cnt_r >= SETUP_MIN && hi_cnt_r <= SETUP_TGT + 2)
		else $error("Entry setup time out of range");
	chk_erase_wait: assert property ($rose(sclk) && erase_pend_r |-> lo_cnt_r >= ERASE_WAIT)
		else $error("Clock started before erase wait");
	chk_low_phase: assert property ($rose(sclk) && entered_r && !erase_pend_r && rise_cnt_r < 32'h180
		|-> lo_cnt_r >= PHASE)
		else $error("Clock low phase too short");
	chk_high_phase: assert property ($fell(sclk) && entered_r |-> hi_cnt_r >= PHASE)
		else $error("Clock high phase too short");
	chk_word_gap: assert property ($rose(sclk) && entered_r && rise_cnt_r != 32'h0 && rise_cnt_r[3:0] == 4'h0
		&& rise_cnt_r <= 32'hC0 |-> lo_cnt_r >= WORD_WAIT)
		else $error("Word write pause too short");
	chk_verify_release: assert property ($rose(sclk) && entered_r && rise_cnt_r >= 32'hC0
		&& rise_cnt_r < 32'h180 |-> !data_prog_oe [*4])
		else $error("Programmer drives data during read-back");
	chk_read_window: assert property (data_dev_oe |-> entered_r && rise_cnt_r > 32'hC0
		&& rise_cnt_r <= 32'h180)
		else $error("Device drives data outside the single read-back");
	chk_bit_timing: assert property (data_dev_oe && $changed(data_dev_o) |-> sclk && $past(sclk, 2))
		else $error("Read-back bit changed outside clock high phase");

	cov_entry: cover property ($rose(erase_pend_r));
	cov_read: cover property ($rose(data_dev_oe));
	cov_sync: cover property (entry && button_input_one);
endmodule

//--- espp_pkg.sv
// Shared constants for the encoder serial programming port
package espp_pkg;

	localparam int CLK_HZ           = 40_000_000;
	localparam int IMAGE_BITS       = 192;
	localparam int WORD_BITS        = 16;
	localparam int IMAGE_WORDS      = IMAGE_BITS / WORD_BITS;
	localparam int SETUP_MIN_US     = 3500;
	localparam int SETUP_MAX_US     = 4500;
	localparam int SETUP_TGT_US     = 4000;
	localparam int ERASE_WAIT_US    = 4000;
	localparam int CLK_PHASE_US     = 50;
	localparam int WORD_WRITE_US    = 50000;
	localparam int ERASE_OP_US      = 2000;
	localparam int WRITE_OP_US      = 10000;
	localparam int VERIFY_DELAY_US  = 4000;

	localparam int SETUP_MIN_CYC    = (SETUP_MIN_US * (CLK_HZ / 1_000_000));
	localparam int SETUP_MAX_CYC    = (SETUP_MAX_US * (CLK_HZ / 1_000_000));
	localparam int SETUP_TGT_CYC    = (SETUP_TGT_US * (CLK_HZ / 1_000_000));
	localparam int ERASE_WAIT_CYC   = (ERASE_WAIT_US * (CLK_HZ / 1_000_000));
	localparam int CLK_PHASE_CYC    = (CLK_PHASE_US * (CLK_HZ / 1_000_000));
	localparam int WORD_WRITE_CYC   = (WORD_WRITE_US * (CLK_HZ / 1_000_000));
	localparam int ERASE_OP_CYC     = (ERASE_OP_US * (CLK_HZ / 1_000_000));
	localparam int WRITE_OP_CYC     = (WRITE_OP_US * (CLK_HZ / 1_000_000));
	localparam int VERIFY_DELAY_CYC = (VERIFY_DELAY_US * (CLK_HZ / 1_000_000));

	localparam logic [IMAGE_BITS-1:0] IMAGE_RESET = '0;

endpackage

//--- espp_programmer.sv
// Programmer end: entry sequence, image upload and verify read-back
`timescale 1ns/100ps
module espp_programmer #(
	parameter int SETUP_TGT  = espp_pkg::SETUP_TGT_CYC,
	parameter int ERASE_WAIT = espp_pkg::ERASE_WAIT_US * SETUP_TGT / espp_pkg::SETUP_TGT_US,
	parameter int PHASE      = espp_pkg::CLK_PHASE_CYC,
	parameter int WORD_WAIT  = espp_pkg::WORD_WRITE_CYC
) (
	input  wire logic                            clock,
	input  wire logic                            nrst,
	espp_if.programmer                           link,
	input  wire logic                            start,
	input  wire logic                            sync_req,
	input  wire logic [espp_pkg::IMAGE_BITS-1:0] image,
	output logic                                 busy,
	output logic                                 done,
	output logic                                 verify_ok,
	output logic [espp_pkg::IMAGE_BITS-1:0]      readback
);

	localparam int IB = espp_pkg::IMAGE_BITS;
	localparam int WB = espp_pkg::WORD_BITS;

	initial
	begin
		if (PHASE < 2 || SETUP_TGT < 1 || ERASE_WAIT < 1 || WORD_WAIT < 1)
			$error("espp_programmer: bad timing parameters");
	end

	typedef enum logic [2:0] {
		P_IDLE   = 3'b000,
		P_SETUP  = 3'b001,
		P_ENTER  = 3'b011,
		P_ERASE  = 3'b010,
		P_SEND   = 3'b110,
		P_WAIT   = 3'b111,
		P_VERIFY = 3'b101,
		P_END    = 3'b100
	} espp_pstate_e;

	logic [1:0]   din_s_r;
	espp_pstate_e state_r;
	logic [31:0]  cnt_r;
	logic [7:0]   bit_r;
	logic         sclk_r, data_r, data_oe_r, sel_r, done_r, ok_r;
	logic [IB-1:0] img_r, rb_r;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			din_s_r <= 2'h0;
		else
			din_s_r <= {din_s_r[0], link.data_line};
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r   <= P_IDLE;
			cnt_r     <= 32'h0;
			bit_r     <= 8'h0;
			sclk_r    <= 1'b0;
			data_r    <= 1'b0;
			data_oe_r <= 1'b0;
			sel_r     <= 1'b0;
			done_r    <= 1'b0;
			ok_r      <= 1'b0;
			img_r     <= '0;
			rb_r      <= '0;
		end
		else
		begin
			cnt_r <= cnt_r + 32'h1;
			case (state_r)
				P_IDLE:
				begin
					cnt_r <= 32'h0;
					if (start)
					begin
						state_r <= P_SETUP;
						img_r   <= image;
						sclk_r  <= 1'b1;
						done_r  <= 1'b0;
						ok_r    <= 1'b0;
						sel_r   <= sync_req;
					end
				end
				P_SETUP:
				begin
					if (cnt_r >= 32'(SETUP_TGT - 1))
					begin
						data_r    <= 1'b1;
						data_oe_r <= 1'b1;
						state_r   <= P_ENTER;
						cnt_r     <= 32'h0;
					end
				end
				P_ENTER:
				begin
					if (cnt_r >= 32'(PHASE - 1))
					begin
						sclk_r    <= 1'b0;
						data_r    <= 1'b0;
						cnt_r     <= 32'h0;
						state_r   <= sel_r ? P_END : P_ERASE;
					end
				end
				P_ERASE:
				begin
					if (cnt_r >= 32'(ERASE_WAIT - 1))
					begin
						state_r <= P_SEND;
						bit_r   <= 8'h0;
						cnt_r   <= 32'h0;
						data_r  <= img_r[0];
						sclk_r  <= 1'b1;
					end
				end
				P_SEND:
				begin
					if (cnt_r >= 32'(PHASE - 1))
					begin
						cnt_r  <= 32'h0;
						sclk_r <= ~sclk_r;
						if (sclk_r)
						begin
							bit_r <= bit_r + 8'h1;
							if (bit_r[3:0] == 4'hF)
								state_r <= P_WAIT;
						end
						else
							data_r <= img_r[bit_r];
					end
				end
				P_WAIT:
				begin
					if (cnt_r >= 32'(WORD_WAIT - 1))
					begin
						cnt_r <= 32'h0;
						if (32'(bit_r) >= 32'(IB))
						begin
							state_r   <= P_VERIFY;
							data_oe_r <= 1'b0;
							bit_r     <= 8'h0;
						end
						else
						begin
							state_r <= P_SEND;
							data_r  <= img_r[bit_r];
							sclk_r  <= 1'b1;
						end
					end
				end
				P_VERIFY:
				begin
					if (cnt_r >= 32'(PHASE - 1))
					begin
						cnt_r  <= 32'h0;
						sclk_r <= ~sclk_r;
						if (sclk_r)
						begin
							rb_r[bit_r] <= din_s_r[1];
							bit_r       <= bit_r + 8'h1;
							if (32'(bit_r) == 32'(IB - 1))
								state_r <= P_END;
						end
					end
				end
				P_END:
				begin
					sclk_r    <= 1'b0;
					data_oe_r <= 1'b0;
					done_r    <= 1'b1;
					ok_r      <= ~sel_r && (rb_r == img_r);
					state_r   <= P_IDLE;
				end
				default:
					state_r <= P_IDLE;
			endcase
		end
	end

	assign link.sclk_o       = sclk_r;
	assign link.sclk_oe      = 1'b1;
	// Held one cycle past the clock fall so the far end sees it at the edge
	assign link.b1_o         = sel_r && ((state_r == P_ENTER) || (state_r == P_END));
	assign link.b0_o         = 1'b0;
	assign link.data_prog_o  = data_r;
	assign link.data_prog_oe = data_oe_r;
	assign busy              = (state_r != P_IDLE);
	assign done              = done_r;
	assign verify_ok         = ok_r;
	assign readback          = rb_r;

endmodule

//--- tb_top.sv
// Bench for both link ends and a lone device
`timescale 1ns/100ps
module tb_top;
	localparam logic [191:0] PAT_A = 192'h0123456789ABCDEFF0E1D2C3B4A596877869A5B4C3D2E1F0;
	logic         clock;
	logic         nrst;
	logic         start;
	logic         sync_req;
	logic         seen_sync;
	logic [191:0] img;
	logic         busy;
	logic         done;
	logic         verify_ok;
	logic [191:0] readback;
	logic         prog_active;
	logic         sync_mode;
	logic         verify_done;
	logic [191:0] image;
	logic         verify_done2;
	logic [191:0] image2;
	logic         prog_active2;
	logic         write_busy2;
	int           err_total;
	int           checks_done;

	espp_if lk ();
	espp_if lk2 ();
	espp_programmer #(.SETUP_TGT(40), .PHASE(8), .WORD_WAIT(80)) espp_programmer_i (
		.clock(clock), .nrst(nrst), .link(lk.programmer), .start(start), .sync_req(sync_req), .image(img),
		.busy(busy), .done(done), .verify_ok(verify_ok), .readback(readback));
	espp_device #(.SETUP_MIN(20)) espp_device_i (
		.clock(clock), .nrst(nrst), .link(lk.device), .prog_active(prog_active), .sync_mode(sync_mode),
		.write_busy(), .verify_done(verify_done), .image(image));
	espp_device #(.SETUP_MIN(20)) espp_device_i2 (
		.clock(clock), .nrst(nrst), .link(lk2.device), .prog_active(prog_active2), .sync_mode(),
		.write_busy(write_busy2), .verify_done(verify_done2), .image(image2));
	espp_monitor espp_monitor_i (
		.clock(clock), .nrst(nrst), .serial_clock_button_input(lk.serial_clock_button_input),
		.button_input_one(lk.button_input_one), .button_input_zero(lk.button_input_zero),
		.data_line(lk.data_line), .data_prog_oe(lk.data_prog_oe), .data_dev_oe(lk.data_dev_oe),
		.data_dev_o(lk.data_dev_o));

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [191:0] seen, input logic [191:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic pin(input logic c, input logic d, input logic oe, input int n);
		lk2.sclk_o = c;
		lk2.data_prog_o = d;
		lk2.data_prog_oe = oe;
		cyc(n);
	endtask

	// Bit held across both phases, taken at the fall
	task automatic bit2(input logic d, input logic oe, input logic exp, input logic rd);
		pin(1'b1, d, oe, 8);
		if (rd)
			check("link bit", lk2.data_line, exp);
		pin(1'b0, d, oe, 8);
	endtask

	task automatic enter2;
		pin(1'b1, 1'b0, 1'b0, 40);
		pin(1'b1, 1'b1, 1'b1, 8);
		pin(1'b0, 1'b0, 1'b1, 40);
	endtask

	task automatic run_prog(input logic sreq, input logic [191:0] d);
		int n;
		n = 0;
		sync_req = sreq;
		img = d;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		seen_sync = 1'b0;
		while (busy !== 1'b0 && n < 20000)
		begin
			seen_sync = seen_sync | (sync_mode === 1'b1);
			cyc(1);
			n++;
		end
		// Device lags the programmer by its pin synchronisers
		repeat (8)
		begin
			seen_sync = seen_sync | (sync_mode === 1'b1);
			cyc(1);
		end
		if (n == 20000)
		begin
			$display("MISMATCH busy expected 0 seen 1");
			err_total++;
			finish_test();
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_upload(input logic [191:0] d);
		run_prog(1'b0, d);
		check("done", done, 1'b1);
		check("verify_ok", verify_ok, 1'b1);
		check("readback", readback, d);
		check("image", image, d);
		check("verify_done", verify_done, 1'b1);
		check("prog_active", prog_active, 1'b0);
		$display("test_upload ended");
	endtask

	task automatic test_sync;
		run_prog(1'b1, PAT_A);
		check("sync_mode", seen_sync, 1'b1);
		check("image kept", image, ~PAT_A);
		check("prog_active sync", prog_active, 1'b0);
		$display("test_sync ended");
	endtask

	task automatic test_verify_guard;
		for (int i = 0; i < 16; i++)
			bit2(1'b0, 1'b0, 1'b0, 1'b1);
		enter2();
		for (int i = 0; i < 192; i++)
		begin
			bit2(PAT_A[i], 1'b1, 1'b0, 1'b0);
			if (i % 16 == 15)
			begin
				pin(1'b0, PAT_A[i], 1'b1, 8);
				check("write_busy2", write_busy2, 1'b1);
				pin(1'b0, PAT_A[i], 1'b1, 72);
				check("write_busy2 idle", write_busy2, 1'b0);
			end
		end
		check("image2", image2, PAT_A);
		for (int i = 0; i < 208; i++)
			bit2(1'b0, 1'b0, (i < 192) ? PAT_A[i] : 1'b0, 1'b1);
		check("verify_done2", verify_done2, 1'b1);
		check("prog_active2", prog_active2, 1'b0);
		$display("test_verify_guard ended");
	endtask

	task automatic test_erase;
		enter2();
		check("erased image2", image2, 192'h0);
		check("prog_active2 load", prog_active2, 1'b1);
		$display("test_erase ended");
	endtask

	initial
	begin
		err_total = 0;
		checks_done = 0;
		nrst = 1'b0;
		start = 1'b0;
		sync_req = 1'b0;
		img = '0;
		lk2.sclk_o = 1'b0;
		lk2.sclk_oe = 1'b1;
		lk2.b1_o = 1'b0;
		lk2.b0_o = 1'b0;
		lk2.data_prog_o = 1'b0;
		lk2.data_prog_oe = 1'b0;
		cyc(8);
		nrst = 1'b1;
		cyc(2);
		test_upload(PAT_A);
		test_upload(~PAT_A);
		test_sync();
		test_verify_guard();
		test_erase();
		finish_test();
	end
endmodule
